// ===== include/rcmr_defs.svh
`ifndef RCMR_DEFS_SVH
`define RCMR_DEFS_SVH

// Register addresses on the memory-mapped register bus.
`define RCMR_ADDR_REMAP 32'hffff0220
`define RCMR_ADDR_STATUS 32'hffff0230
`define RCMR_ADDR_CLEAR 32'hffff0234

// Field positions.
`define RCMR_BIT_POR 0
`define RCMR_BIT_WDT 1
`define RCMR_BIT_SW 2
`define RCMR_BIT_EXT 3
`define RCMR_BIT_REMAP 0

// Reset values.
`define RCMR_STATUS_RST 4'h1
`define RCMR_REMAP_RST 1'b0

// Defined memory regions, inclusive bounds.
`define RCMR_REMAP_LO 32'h00000000
`define RCMR_REMAP_HI 32'h00017fff
`define RCMR_SRAM_LO 32'h00040000
`define RCMR_SRAM_HI 32'h000417ff
`define RCMR_FLASH_LO 32'h00080000
`define RCMR_FLASH_HI 32'h00097fff
`define RCMR_MMR_LO 32'hffff0000

// Timing: internal reset pulse length.
`define RCMR_CLK_PERIOD_NS 50
`define RCMR_RST_MIN_NS 200
`define RCMR_RST_CYCLES ((`RCMR_RST_MIN_NS + `RCMR_CLK_PERIOD_NS - 1) / `RCMR_CLK_PERIOD_NS)

`endif

// ===== include/rcmr_pkg.sv
`default_nettype none

package rcmr_pkg;
    typedef enum logic [0:0] {
        RCMR_RUN = 1'b0,
        RCMR_RESET = 1'b1
    } rcmr_state_t;
endpackage

`default_nettype wire

// ===== hdl/rcmr_sync.sv
`default_nettype none

module rcmr_sync #(
    parameter int WIDTH = 1,
    parameter logic RST_VAL = 1'b0
) (
    input wire logic i_ref_clk, // System clock.
    input wire logic i_nrst, // Asynchronous reset, active low.
    input wire logic [WIDTH-1:0] i_async, // Inputs from outside the clock domain.
    output logic [WIDTH-1:0] o_sync // Synchronised copies.
);
    if (WIDTH < 1) begin : g_bad_width
        $error("rcmr_sync: WIDTH must be at least 1.");
    end

    // The first stage feeds only the second; no logic looks at it.
    genvar g;
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
        logic meta_q;
        always_ff @(posedge i_ref_clk or negedge i_nrst) begin
            if (!i_nrst) begin
                meta_q <= RST_VAL;
                o_sync[g] <= RST_VAL;
            end else begin
                meta_q <= i_async[g];
                o_sync[g] <= meta_q;
            end
        end
    end
endmodule

`default_nettype wire

// ===== hdl/rcmr_top.sv
// Functional notes
// - Record which of four sources have reset since the last clear.
// - Power-on reset sets cause bit 0.
// - Watchdog timeout sets cause bit 1.
// - External pin reset sets cause bit 3.
// - Writing cause bit 2 triggers software reset.
// - Cause bits 7 to 4 read zero.
// - Clear register ones clear matching cause bits.
// - Clear write keeping bit 2 re-triggers reset.
// - Every reset resets everything; only power-on resets cause register.
// - Power-on SRAM validity follows low-voltage flag.
// - Remap bit maps SRAM at address zero.
// - Any reset restores flash mapping.
// - Unmapped access raises a data abort.
`default_nettype none
`include "rcmr_defs.svh"

module rcmr_top #(
    parameter int RST_CYCLES = `RCMR_RST_CYCLES
) (
    input wire logic i_ref_clk, // System clock, 20 MHz.
    input wire logic i_nrst, // Power-on reset, async, active low.
    input wire logic i_ce, // Clock enable; low freezes all state except the external pin synchroniser.
    input wire logic i_ext_rst_n, // External reset pin, active low.
    input wire logic i_wdt_timeout, // Watchdog timeout pulse.
    input wire logic i_lin_dl_done, // LIN download finished pulse.
    input wire logic i_lvf_enable, // Low-voltage flag enabled.
    input wire logic i_lvf_status, // Low-voltage flag status bit.
    input wire logic [31:0] i_bus_addr, // Core byte address.
    input wire logic i_bus_rd, // Read strobe, one cycle.
    input wire logic i_bus_wr, // Write strobe, one cycle.
    input wire logic [7:0] i_bus_wdata, // Write data.
    output logic [7:0] o_bus_rdata, // Read data, one cycle after strobe.
    output logic o_bus_abort, // Data abort pulse.
    output logic o_sys_rst_n, // System reset tree, active low.
    output logic o_remap_sram, // High: SRAM mapped at address zero.
    output logic o_sram_valid // SRAM contents survived the last reset.
);
    // The reload counter is eight bits wide, so longer pulses cannot be served.
    if (RST_CYCLES < 1 || RST_CYCLES > 255) begin : g_bad_rst_cycles
        $error("rcmr_top: RST_CYCLES must be 1 to 255.");
    end

    rcmr_pkg::rcmr_state_t state_q;
    logic [7:0] cnt_q;
    logic [3:0] status_q;
    logic lin_dl_q;
    logic por_eval_q;
    logic ext_n_sync;
    logic run;
    logic acc;
    logic mapped;
    logic wr_status;
    logic wr_clear;
    logic wr_remap;
    logic sw_req;
    logic [3:0] set_vec;
    logic [3:0] clr_vec;
    logic trigger;

    rcmr_sync #(
        .WIDTH(1),
        .RST_VAL(1'b1)
    ) u_ext_sync (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_async(i_ext_rst_n),
        .o_sync(ext_n_sync)
    );

    // Bus requests are ignored while the system reset tree is asserted.
    assign run = (state_q == rcmr_pkg::RCMR_RUN);
    assign acc = run && (i_bus_rd || i_bus_wr);
    assign mapped = (i_bus_addr <= `RCMR_REMAP_HI) ||
                    (i_bus_addr >= `RCMR_SRAM_LO && i_bus_addr <= `RCMR_SRAM_HI) ||
                    (i_bus_addr >= `RCMR_FLASH_LO && i_bus_addr <= `RCMR_FLASH_HI) ||
                    (i_bus_addr >= `RCMR_MMR_LO);
    assign wr_status = run && i_bus_wr && (i_bus_addr == `RCMR_ADDR_STATUS);
    assign wr_clear = run && i_bus_wr && (i_bus_addr == `RCMR_ADDR_CLEAR);
    assign wr_remap = run && i_bus_wr && (i_bus_addr == `RCMR_ADDR_REMAP);

    // A clear write that leaves the software bit set asks for another reset.
    assign sw_req = (wr_status && i_bus_wdata[`RCMR_BIT_SW]) ||
                    (wr_clear && status_q[`RCMR_BIT_SW] &&
                     !i_bus_wdata[`RCMR_BIT_SW]);

    always_comb begin
        set_vec = 4'h0;
        set_vec[`RCMR_BIT_WDT] = run && i_wdt_timeout;
        set_vec[`RCMR_BIT_SW] = sw_req;
        set_vec[`RCMR_BIT_EXT] = run && !ext_n_sync;
        clr_vec = wr_clear ? i_bus_wdata[3:0] : 4'h0;
    end

    assign trigger = |set_vec[3:1];

    // Cause record survives every reset but power-on; a set beats a clear.
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            status_q <= `RCMR_STATUS_RST;
        end else if (i_ce) begin
            status_q <= (status_q & ~clr_vec) | set_vec;
        end
    end

    // Reset pulse: at least RST_CYCLES long, stretched while the pin is held.
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_q <= rcmr_pkg::RCMR_RUN;
            cnt_q <= 8'h00;
            o_sys_rst_n <= 1'b0;
        end else if (i_ce) begin
            case (state_q)
                rcmr_pkg::RCMR_RUN: begin
                    o_sys_rst_n <= !trigger;
                    if (trigger) begin
                        state_q <= rcmr_pkg::RCMR_RESET;
                        cnt_q <= 8'(RST_CYCLES - 1);
                    end
                end
                rcmr_pkg::RCMR_RESET: begin
                    if (!ext_n_sync) begin
                        cnt_q <= 8'(RST_CYCLES - 1);
                    end else if (cnt_q == 8'h00) begin
                        state_q <= rcmr_pkg::RCMR_RUN;
                        o_sys_rst_n <= 1'b1;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                default: begin
                    state_q <= rcmr_pkg::RCMR_RUN;
                    o_sys_rst_n <= 1'b1;
                end
            endcase
        end
    end

    // Only bit 0 is stored; reserved bits are dropped, not trusted to be zero.
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_remap_sram <= `RCMR_REMAP_RST;
        end else if (i_ce) begin
            if (trigger || !run) begin
                o_remap_sram <= `RCMR_REMAP_RST;
            end else if (wr_remap) begin
                o_remap_sram <= i_bus_wdata[`RCMR_BIT_REMAP];
            end
        end
    end

    // The flag level is sampled one edge after power-on release, never under reset.
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            lin_dl_q <= 1'b0;
            por_eval_q <= 1'b1;
            o_sram_valid <= 1'b0;
        end else if (i_ce) begin
            por_eval_q <= 1'b0;
            if (por_eval_q) begin
                o_sram_valid <= i_lvf_enable && i_lvf_status;
            end else if (trigger) begin
                o_sram_valid <= !lin_dl_q;
            end
            if (trigger) begin
                lin_dl_q <= 1'b0;
            end else if (i_lin_dl_done) begin
                lin_dl_q <= 1'b1;
            end
        end
    end

    // Read answer and abort one cycle after the strobe.
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_bus_rdata <= 8'h00;
            o_bus_abort <= 1'b0;
        end else if (i_ce) begin
            o_bus_abort <= acc && !mapped;
            if (run && i_bus_rd) begin
                case (i_bus_addr)
                    `RCMR_ADDR_STATUS: o_bus_rdata <= {4'h0, status_q};
                    `RCMR_ADDR_REMAP: o_bus_rdata <= {7'h00, o_remap_sram};
                    default: o_bus_rdata <= 8'h00;
                endcase
            end
        end
    end

    // Length of the current low phase of the reset tree, for the pulse check only.
    logic [8:0] low_len_q;
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            low_len_q <= 9'h000;
        end else if (i_ce) begin
            if (o_sys_rst_n) begin
                low_len_q <= 9'h000;
            end else if (low_len_q != 9'h1ff) begin
                low_len_q <= low_len_q + 9'h001;
            end
        end
    end

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_nrst);

    AST_RSV_ZERO: assert property (o_bus_rdata[7:4] == 4'h0)
        else $error("Upper cause bits read nonzero.");
    AST_WDT_SET: assert property (i_ce && run && i_wdt_timeout |=>
        status_q[`RCMR_BIT_WDT] && !o_sys_rst_n)
        else $error("Watchdog cause not recorded.");
    AST_EXT_SET: assert property (i_ce && run && !ext_n_sync |=>
        status_q[`RCMR_BIT_EXT] && !o_sys_rst_n)
        else $error("External cause not recorded.");
    AST_SW_RST: assert property (i_ce && wr_status && i_bus_wdata[2] |=>
        status_q[`RCMR_BIT_SW] && !o_sys_rst_n && !o_remap_sram)
        else $error("Software reset not performed.");
    AST_CLR_POR: assert property (i_ce && wr_clear && i_bus_wdata[0] |=>
        !status_q[`RCMR_BIT_POR])
        else $error("Clear write did not clear power-on bit.");
    AST_RETRIG: assert property (i_ce && wr_clear && status_q[2] && !i_bus_wdata[2]
        |=> !o_sys_rst_n)
        else $error("Clear write did not re-trigger reset.");
    AST_REMAP_SET: assert property (i_ce && wr_remap && i_bus_wdata[0] && !trigger
        |=> o_remap_sram)
        else $error("Remap bit did not set.");
    AST_REMAP_RST: assert property (!o_sys_rst_n |-> !o_remap_sram)
        else $error("Remap held during reset.");
    AST_PULSE: assert property ($rose(o_sys_rst_n) && !$past(por_eval_q) |->
        low_len_q >= 9'(RST_CYCLES))
        else $error("Reset pulse too short.");
    AST_ABORT: assert property (i_ce && acc && !mapped |=> o_bus_abort ##1
        (!o_bus_abort || $past(acc && !mapped)))
        else $error("Unmapped access gave no abort.");
    AST_LIN: assert property (i_ce && trigger && lin_dl_q && !por_eval_q
        |=> !o_sram_valid)
        else $error("SRAM marked valid after LIN download.");

    COV_SW: cover property (wr_status && i_bus_wdata[2] ##1 !o_sys_rst_n);
    COV_WDT: cover property (run && i_wdt_timeout ##[1:20] o_sys_rst_n);
    COV_REMAP: cover property (wr_remap && i_bus_wdata[0] ##1 o_remap_sram);
    COV_ABORT: cover property (o_bus_abort);
endmodule

`default_nettype wire

// ===== verification/rcmr_core_model.sv
`default_nettype none

module rcmr_core_model (
    input wire logic i_ref_clk, // System clock.
    output logic [31:0] o_bus_addr, // Byte address.
    output logic o_bus_rd, // Read strobe.
    output logic o_bus_wr, // Write strobe.
    output logic [7:0] o_bus_wdata // Write data.
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        o_bus_addr = 32'h00000000;
        o_bus_rd = 1'b0;
        o_bus_wr = 1'b0;
        o_bus_wdata = 8'h00;
    end

    // After the strobe the address and data flip, so stale values cannot pass for a hold.
    task automatic access(input logic wr, input logic [31:0] addr, input logic [7:0] data);
        @(posedge i_ref_clk);
        o_bus_addr <= addr;
        o_bus_wr <= wr;
        o_bus_rd <= !wr;
        o_bus_wdata <= data;
        @(posedge i_ref_clk);
        o_bus_rd <= 1'b0;
        o_bus_wr <= 1'b0;
        o_bus_addr <= ~addr;
        o_bus_wdata <= ~data;
    endtask
endmodule

`default_nettype wire

// ===== verification/testbench.sv
`default_nettype none
`include "rcmr_defs.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RST = 4;
    logic i_ref_clk, i_nrst, i_ce, i_ext_rst_n, i_wdt_timeout, i_lin_dl_done;
    logic i_lvf_enable, i_lvf_status, i_bus_rd, i_bus_wr, o_bus_abort;
    logic o_sys_rst_n, o_remap_sram, o_sram_valid;
    logic [31:0] i_bus_addr, a;
    logic [7:0] i_bus_wdata, o_bus_rdata, d;
    int seed, bad_count, checked, i;

    rcmr_core_model u_rcmr_core_model (.i_ref_clk(i_ref_clk), .o_bus_addr(i_bus_addr),
        .o_bus_rd(i_bus_rd), .o_bus_wr(i_bus_wr), .o_bus_wdata(i_bus_wdata));
    rcmr_top #(.RST_CYCLES(RST)) u_rcmr_top (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
        .i_ce(i_ce), .i_ext_rst_n(i_ext_rst_n), .i_wdt_timeout(i_wdt_timeout),
        .i_lin_dl_done(i_lin_dl_done), .i_lvf_enable(i_lvf_enable),
        .i_lvf_status(i_lvf_status), .i_bus_addr(i_bus_addr), .i_bus_rd(i_bus_rd),
        .i_bus_wr(i_bus_wr), .i_bus_wdata(i_bus_wdata), .o_bus_rdata(o_bus_rdata),
        .o_bus_abort(o_bus_abort), .o_sys_rst_n(o_sys_rst_n), .o_remap_sram(o_remap_sram),
        .o_sram_valid(o_sram_valid));

    initial begin
        i_ref_clk = 1'b0;
        forever #25 i_ref_clk = ~i_ref_clk;
    end

    task automatic summarize();
        if (bad_count == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value at %0t: byte %h, want %h", $time, g, e);
        end
    endtask

    task automatic chk1(input logic g, input logic e);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value at %0t: flag %b, want %b", $time, g, e);
        end
    endtask

    function automatic logic hole(input logic [31:0] x);
        return !(x <= 32'h00017fff || (x >= 32'h00040000 && x <= 32'h000417ff) ||
            (x >= 32'h00080000 && x <= 32'h00097fff) || x >= 32'hffff0000);
    endfunction

    task automatic wr(input logic [31:0] x, input logic [7:0] v);
        u_rcmr_core_model.access(1'b1, x, v);
    endtask

    task automatic rd(input logic [31:0] x, input logic [7:0] e);
        u_rcmr_core_model.access(1'b0, x, 8'h00);
        #1;
        chk8(o_bus_rdata, e);
        chk1(o_bus_abort, 1'b0);
    endtask

    // Counts the low cycles of the reset tree; a negative length skips the check of that count.
    task automatic wait_rst(input int exp);
        int n;
        n = 0;
        #1;
        for (int k = 0; k < 400; k++) begin
            if (o_sys_rst_n === 1'b0) n++;
            else if (n > 0 || k > 8) break;
            @(posedge i_ref_clk);
            #1;
        end
        if (exp >= 0) chk8(8'(n), 8'(exp));
        chk1(o_sys_rst_n, 1'b1);
        chk1(o_remap_sram, 1'b0);
    endtask

    task automatic pulse_wdt();
        wr(`RCMR_ADDR_REMAP, 8'h01);
        @(posedge i_ref_clk);
        i_wdt_timeout <= 1'b1;
        @(posedge i_ref_clk);
        i_wdt_timeout <= 1'b0;
    endtask

    initial begin
        #(50 * 4000);
        bad_count++;
        summarize();
    end

    initial begin
        seed = 32174;
        bad_count = 0;
        checked = 0;
        {i_nrst, i_ce, i_ext_rst_n, i_wdt_timeout, i_lin_dl_done} = 5'b01100;
        {i_lvf_enable, i_lvf_status} = 2'($random(seed));
        repeat (12) @(posedge i_ref_clk);
        i_nrst <= 1'b1;
        repeat (2) @(posedge i_ref_clk);
        #1 chk1(o_sram_valid, i_lvf_enable & i_lvf_status);
        rd(`RCMR_ADDR_STATUS, 8'h01);
        rd(`RCMR_ADDR_CLEAR, 8'h00);
        for (i = 0; i < 6; i++) begin
            d = 8'($random(seed)) & 8'h01;
            wr(`RCMR_ADDR_REMAP, d);
            #1 chk1(o_remap_sram, d[0]);
        end
        rd(`RCMR_ADDR_REMAP, {7'h00, d[0]});
        wr(`RCMR_ADDR_CLEAR, 8'h0f);
        rd(`RCMR_ADDR_STATUS, 8'h00);
        pulse_wdt();
        wait_rst(RST);
        rd(`RCMR_ADDR_STATUS, 8'h02);
        wr(`RCMR_ADDR_REMAP, 8'h01);
        i_ext_rst_n <= 1'b0;
        repeat (5) @(posedge i_ref_clk);
        i_ext_rst_n <= 1'b1;
        wait_rst(-1);
        rd(`RCMR_ADDR_STATUS, 8'h0a);
        wr(`RCMR_ADDR_CLEAR, 8'h0a);
        rd(`RCMR_ADDR_STATUS, 8'h00);
        wr(`RCMR_ADDR_STATUS, 8'hf4);
        wait_rst(RST);
        rd(`RCMR_ADDR_STATUS, 8'h04);
        wr(`RCMR_ADDR_CLEAR, 8'hf1);
        wait_rst(RST);
        wr(`RCMR_ADDR_CLEAR, 8'h04);
        repeat (3) @(posedge i_ref_clk);
        #1 chk1(o_sys_rst_n, 1'b1);
        rd(`RCMR_ADDR_STATUS, 8'h00);
        @(posedge i_ref_clk);
        i_lin_dl_done <= 1'b1;
        @(posedge i_ref_clk);
        i_lin_dl_done <= 1'b0;
        pulse_wdt();
        wait_rst(RST);
        chk1(o_sram_valid, 1'b0);
        pulse_wdt();
        wait_rst(RST);
        chk1(o_sram_valid, 1'b1);
        for (i = 0; i < 40; i++) begin
            a = $random(seed);
            if (a[1]) a = a & 32'h000fffff;
            if (i < 8) a = 32'({32'h00018000, 32'h0003ffff, 32'h00041800, 32'h00098000,
                32'hfffeffff, 32'h00017fff, 32'h00040000, 32'hffff0000} >> (32 * (7 - i)));
            u_rcmr_core_model.access(i == 3, a, 8'h00);
            #1 chk1(o_bus_abort, hole(a));
        end
        summarize();
    end
endmodule

`default_nettype wire
